// >>> src/pft_defines.svh
// Constants for the program flash table access control block
`ifndef PFT_DEFINES_SVH
`define PFT_DEFINES_SVH

// Register select codes on the special-function port
`define PFT_REG_CTRL 3'h0
`define PFT_REG_UNLOCK 3'h1
`define PFT_REG_LATCH 3'h2
`define PFT_REG_PTRL 3'h3
`define PFT_REG_PTRH 3'h4
`define PFT_REG_PTRU 3'h5

// Bit positions in memory_access_control
`define PFT_BIT_MSEL 7
`define PFT_BIT_CSEL 6
`define PFT_BIT_FREE 4
`define PFT_BIT_WERR 3
`define PFT_BIT_WEN 2
`define PFT_BIT_WR 1
`define PFT_BIT_RD 0

// Unlock keys
`define PFT_KEY_FIRST 8'h55
`define PFT_KEY_SECOND 8'hAA

// Widths and pointer layout
`define PFT_SFR_AW 3
`define PFT_PTR_W 22
`define PFT_PTR_TOP 21
`define PFT_PTR_UPPER_W 6
`define PFT_HOLD_DEPTH 8
`define PFT_HOLD_RESET 8'hFF
`define PFT_WRITE_MASK 22'h3FFFF8
`define PFT_ERASE_MASK 22'h3FFFC0
`define PFT_BYTE_ZERO 8'h00

// Programming time and clock period
`define PFT_PROG_TIME_NS 2000000
`define PFT_CLK_PERIOD_NS 25

`endif

// >>> src/pft_pkg.sv
// Types shared by the program flash table access control block
`include "pft_defines.svh"
package pft_pkg;
  // Pointer behaviour of a table instruction
  typedef enum logic [1:0] {
    PFT_PTR_KEEP, PFT_PTR_POSTINC, PFT_PTR_POSTDEC, PFT_PTR_PREINC
  } pft_ptr_mode_e;
  // Memory a self-timed cycle acts on
  typedef enum logic [1:0] {PFT_TGT_EEPROM, PFT_TGT_FLASH, PFT_TGT_CONFIG} pft_target_e;
  // Unlock sequence tracker
  typedef enum logic [1:0] {PFT_UNL_IDLE, PFT_UNL_FIRST, PFT_UNL_OPEN} pft_unlock_e;
  // Self-timed cycle sequencer
  typedef enum logic {PFT_SEQ_IDLE, PFT_SEQ_BUSY} pft_seq_e;
  // Special-function register access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`PFT_SFR_AW-1:0] addr;
    logic [7:0] wdata;
  } pft_sfr_req_s;
  // Command handed to the array for one self-timed cycle
  typedef struct packed {
    pft_target_e target;
    logic erase;
    logic [`PFT_PTR_W-1:0] blockAddr;
  } pft_prog_cmd_s;
endpackage

// >>> src/pft_hold_mem.sv
// Holding registers that collect one program block before a timed write
`timescale 1ns/1ps
`include "pft_defines.svh"
module pft_hold_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `PFT_HOLD_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clearAll,
  input wire logic write_enable_bit,
  input wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData
);
  // Storage, one word per entry
  logic [WIDTH-1:0] mem [DEPTH];

  // Each entry returns to the erased value; an erased byte leaves flash alone
  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        mem[i] <= WIDTH'(`PFT_HOLD_RESET);
      end else if (clearAll) begin
        mem[i] <= WIDTH'(`PFT_HOLD_RESET);
      end else if (write_enable_bit && (wrIdx == i)) begin
        mem[i] <= wrData;
      end
    end
  end

  // Registered read port
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= WIDTH'(`PFT_HOLD_RESET);
    end else begin
      rdData <= mem[rdIdx];
    end
  end
endmodule // pft_hold_mem

// >>> src/pft_table_ctrl.sv
// Table pointer, byte latch and self-timed erase/write control
`timescale 1ns/1ps
`include "pft_defines.svh"
// Summary of operation
// - Unlock port stores nothing, reads zero
// - Memory select: set flash, clear EEPROM
// - Configuration select overrides memory select
// - Erase enable makes next flash write erase row
// - Write enable clear at reset, gates writes
// - Error flag set on start, cleared at end
// - Error flag survives reset or improper attempt
// - Write bit set-only, hardware clears at end
// - Completion sets interrupt flag, software clears
// - Read bit one cycle, blocked for flash/config
// - Error leaves both select bits untouched
// - Byte latch is an 8-bit register
// - Pointer is three bytes, 22 bits
// - Auto updates change only low 21 bits
// - Table read uses all 22 bits
// - Timed write uses bits 21 to 3
// - Erase uses bits 21 to 6
// - Table write fills one of eight holding registers
// - Keep, post-increment, post-decrement, pre-increment
// - 55h then AAh before the write bit
// - Holding registers reset to FFh
// - Core stalls until the timer ends
module pft_table_ctrl #(
  parameter int PROG_CYCLES = `PFT_PROG_TIME_NS / `PFT_CLK_PERIOD_NS,
  parameter int HOLD_DEPTH = `PFT_HOLD_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic powerOnRst_n,
  input wire pft_pkg::pft_sfr_req_s sfrReq,
  output logic [7:0] sfrRdata,
  input wire logic tblReq,
  input wire logic tblWrite,
  input wire pft_pkg::pft_ptr_mode_e tblMode,
  output logic tblDone,
  output logic flashRdReq,
  output logic [`PFT_PTR_W-1:0] flashRdAddr,
  input wire logic [7:0] flashRdData,
  output logic progStart,
  output pft_pkg::pft_prog_cmd_s progCmd,
  input wire logic [$clog2(HOLD_DEPTH)-1:0] holdRdIdx,
  output logic [7:0] holdRdData,
  output logic eeRdStrobe,
  output logic cpuStall,
  input wire logic irqFlagClr,
  output logic nvWriteIrqFlag
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int HIDX_W = $clog2(HOLD_DEPTH);

  // True when the core writes the given register this cycle
  function automatic logic sfrWrHit(input pft_pkg::pft_sfr_req_s r,
                                    input logic [`PFT_SFR_AW-1:0] idx);
    return r.wr && (r.addr == idx);
  endfunction

  // Steps the pointer by one; the top bit never moves
  function automatic logic [`PFT_PTR_W-1:0] ptrStep(input logic [`PFT_PTR_W-1:0] p,
                                                   input logic up);
    logic [`PFT_PTR_TOP-1:0] low;
    low = up ? p[`PFT_PTR_TOP-1:0] + 21'h1 : p[`PFT_PTR_TOP-1:0] - 21'h1;
    return {p[`PFT_PTR_TOP], low};
  endfunction

  // Control bits
  logic memSel; // Flash when set, EEPROM when clear
  logic cfgSel; // Configuration space when set
  logic eraseEn; // Next start erases a row
  logic writeErr; // Premature termination flag
  logic writeEn; // Permits self-timed cycles
  logic writeGo; // Self-timed cycle in flight
  // Table state
  logic [7:0] latchByte; // Byte moved by table operations
  logic [`PFT_PTR_W-1:0] table_pointer; // Three joined pointer bytes
  logic rdPending; // Table read awaiting array data
  // Sequencer
  pft_pkg::pft_unlock_e unlockState;
  pft_pkg::pft_seq_e seqState;
  logic [CNT_W-1:0] progCnt;
  logic seqDone; // Last cycle of the programming timer

  // Decoded requests
  logic ctrlWr;
  logic startReq; // Software tries to set the write bit
  logic startOk; // Attempt passes unlock and enable checks
  logic tblAccept;
  logic [`PFT_PTR_W-1:0] accessAddr;
  logic [`PFT_PTR_W-1:0] next_table_pointer;
  assign ctrlWr = sfrWrHit(sfrReq, `PFT_REG_CTRL);
  assign startReq = ctrlWr && sfrReq.wdata[`PFT_BIT_WR] && !writeGo;
  assign startOk = startReq && (unlockState == pft_pkg::PFT_UNL_OPEN)
                   && sfrReq.wdata[`PFT_BIT_WEN];
  assign seqDone = (seqState == pft_pkg::PFT_SEQ_BUSY)
                   && (progCnt == CNT_W'(PROG_CYCLES - 1));
  // Table instructions wait while the array is busy or a read is open
  assign tblAccept = tblReq && (seqState == pft_pkg::PFT_SEQ_IDLE) && !rdPending;
  // Address used by this access and pointer left behind it
  always_comb begin
    accessAddr = table_pointer;
    next_table_pointer = table_pointer;
    case (tblMode)
      pft_pkg::PFT_PTR_KEEP: next_table_pointer = table_pointer;
      pft_pkg::PFT_PTR_POSTINC: next_table_pointer = ptrStep(table_pointer, 1'b1);
      pft_pkg::PFT_PTR_POSTDEC: next_table_pointer = ptrStep(table_pointer, 1'b0);
      pft_pkg::PFT_PTR_PREINC: begin
        next_table_pointer = ptrStep(table_pointer, 1'b1);
        accessAddr = next_table_pointer;
      end
      default: next_table_pointer = table_pointer;
    endcase
  end
  // Unlock tracker: only two back-to-back key writes open the gate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlockState <= pft_pkg::PFT_UNL_IDLE;
    end else if (sfrReq.wr) begin
      if (sfrWrHit(sfrReq, `PFT_REG_UNLOCK) && sfrReq.wdata == `PFT_KEY_FIRST) begin
        unlockState <= pft_pkg::PFT_UNL_FIRST;
      end else if (sfrWrHit(sfrReq, `PFT_REG_UNLOCK) && sfrReq.wdata == `PFT_KEY_SECOND
                   && unlockState == pft_pkg::PFT_UNL_FIRST) begin
        unlockState <= pft_pkg::PFT_UNL_OPEN;
      end else begin
        // Any other write, the start itself included, closes the gate
        unlockState <= pft_pkg::PFT_UNL_IDLE;
      end
    end
  end
  // Select bits sit on power-on reset only so an error stays traceable
  always_ff @(posedge core_clk or negedge powerOnRst_n) begin
    if (!powerOnRst_n) begin
      memSel <= 1'b0;
      cfgSel <= 1'b0;
    end else if (ctrlWr) begin
      memSel <= sfrReq.wdata[`PFT_BIT_MSEL];
      cfgSel <= sfrReq.wdata[`PFT_BIT_CSEL];
    end
  end
  // Error flag: not touched by the ordinary reset, so an abort shows
  always_ff @(posedge core_clk or negedge powerOnRst_n) begin
    if (!powerOnRst_n) begin
      writeErr <= 1'b0;
    end else if (startReq) begin
      // Set on any start, legal or not; an illegal one never clears it
      writeErr <= 1'b1;
    end else if (seqDone) begin
      writeErr <= 1'b0;
    end else if (ctrlWr) begin
      writeErr <= sfrReq.wdata[`PFT_BIT_WERR];
    end
  end
  // Erase and write enables
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eraseEn <= 1'b0;
      writeEn <= 1'b0;
    end else if (ctrlWr) begin
      eraseEn <= sfrReq.wdata[`PFT_BIT_FREE];
      writeEn <= sfrReq.wdata[`PFT_BIT_WEN];
    end else if (seqDone && progCmd.erase) begin
      eraseEn <= 1'b0;
    end
  end
  // Write bit: software can only raise it, the timer drops it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      writeGo <= 1'b0;
    end else if (startOk) begin
      writeGo <= 1'b1;
    end else if (seqDone) begin
      writeGo <= 1'b0;
    end
  end
  // Read bit lasts one cycle; judged on the selects being written, so no data read on a flash move
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eeRdStrobe <= 1'b0;
    end else begin
      eeRdStrobe <= ctrlWr && sfrReq.wdata[`PFT_BIT_RD]
                    && !sfrReq.wdata[`PFT_BIT_MSEL] && !sfrReq.wdata[`PFT_BIT_CSEL];
    end
  end
  // Programming timer and stall
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seqState <= pft_pkg::PFT_SEQ_IDLE;
      progCnt <= '0;
      cpuStall <= 1'b0;
    end else begin
      case (seqState)
        pft_pkg::PFT_SEQ_IDLE: begin
          progCnt <= '0;
          if (startOk) begin
            seqState <= pft_pkg::PFT_SEQ_BUSY;
            cpuStall <= 1'b1;
          end
        end
        pft_pkg::PFT_SEQ_BUSY: begin
          progCnt <= progCnt + CNT_W'(1);
          if (seqDone) begin
            seqState <= pft_pkg::PFT_SEQ_IDLE;
            cpuStall <= 1'b0;
          end
        end
        default: seqState <= pft_pkg::PFT_SEQ_IDLE;
      endcase
    end
  end
  // Command to the array, captured at the start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      progStart <= 1'b0;
      progCmd <= '0;
    end else begin
      progStart <= startOk;
      if (startOk) begin
        if (cfgSel) begin
          progCmd.target <= pft_pkg::PFT_TGT_CONFIG;
        end else if (memSel) begin
          progCmd.target <= pft_pkg::PFT_TGT_FLASH;
        end else begin
          progCmd.target <= pft_pkg::PFT_TGT_EEPROM;
        end
        progCmd.erase <= sfrReq.wdata[`PFT_BIT_FREE] && !cfgSel && memSel;
        if (sfrReq.wdata[`PFT_BIT_FREE]) begin
          progCmd.blockAddr <= table_pointer & `PFT_ERASE_MASK;
        end else begin
          progCmd.blockAddr <= table_pointer & `PFT_WRITE_MASK;
        end
      end
    end
  end
  // Completion flag; a new completion beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvWriteIrqFlag <= 1'b0;
    end else if (seqDone) begin
      nvWriteIrqFlag <= 1'b1;
    end else if (irqFlagClr) begin
      nvWriteIrqFlag <= 1'b0;
    end
  end
  // Table pointer: byte writes from the core, steps from table accesses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer <= '0;
    end else if (tblAccept) begin
      table_pointer <= next_table_pointer;
    end else begin
      if (sfrWrHit(sfrReq, `PFT_REG_PTRL)) begin
        table_pointer[7:0] <= sfrReq.wdata;
      end
      if (sfrWrHit(sfrReq, `PFT_REG_PTRH)) begin
        table_pointer[15:8] <= sfrReq.wdata;
      end
      if (sfrWrHit(sfrReq, `PFT_REG_PTRU)) begin
        table_pointer[21:16] <= sfrReq.wdata[`PFT_PTR_UPPER_W-1:0];
      end
    end
  end
  // Table read path: request out, data back next cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flashRdReq <= 1'b0;
      flashRdAddr <= '0;
      rdPending <= 1'b0;
      tblDone <= 1'b0;
    end else begin
      flashRdReq <= tblAccept && !tblWrite;
      rdPending <= tblAccept && !tblWrite;
      if (tblAccept && !tblWrite) begin
        flashRdAddr <= accessAddr;
      end
      // Writes finish at once; reads when the array byte lands
      tblDone <= (tblAccept && tblWrite) || rdPending;
    end
  end
  // Byte latch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latchByte <= '0;
    end else if (rdPending) begin
      latchByte <= flashRdData;
    end else if (sfrWrHit(sfrReq, `PFT_REG_LATCH)) begin
      latchByte <= sfrReq.wdata;
    end
  end
  // Holding registers, cleared after every completed cycle
  pft_hold_mem #(
    .WIDTH(8),
    .DEPTH(HOLD_DEPTH)
  ) uHold (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clearAll(seqDone),
    .write_enable_bit(tblAccept && tblWrite),
    .wrIdx(accessAddr[HIDX_W-1:0]),
    .wrData(latchByte),
    .rdIdx(holdRdIdx),
    .rdData(holdRdData)
  );
  // Register read-back, one cycle after the read strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdata <= '0;
    end else if (sfrReq.rd) begin
      case (sfrReq.addr)
        `PFT_REG_CTRL: begin
          sfrRdata <= `PFT_BYTE_ZERO;
          sfrRdata[`PFT_BIT_MSEL] <= memSel;
          sfrRdata[`PFT_BIT_CSEL] <= cfgSel;
          sfrRdata[`PFT_BIT_FREE] <= eraseEn;
          sfrRdata[`PFT_BIT_WERR] <= writeErr;
          sfrRdata[`PFT_BIT_WEN] <= writeEn;
          sfrRdata[`PFT_BIT_WR] <= writeGo;
          sfrRdata[`PFT_BIT_RD] <= eeRdStrobe;
        end
        `PFT_REG_UNLOCK: sfrRdata <= `PFT_BYTE_ZERO;
        `PFT_REG_LATCH: sfrRdata <= latchByte;
        `PFT_REG_PTRL: sfrRdata <= table_pointer[7:0];
        `PFT_REG_PTRH: sfrRdata <= table_pointer[15:8];
        `PFT_REG_PTRU: sfrRdata <= {2'h0, table_pointer[21:16]};
        default: sfrRdata <= `PFT_BYTE_ZERO;
      endcase
    end
  end
  // Checks
  sequence sqUnlocked;
    unlockState == pft_pkg::PFT_UNL_OPEN;
  endsequence
  sequence sqLaunch;
    ##1 (writeGo && progStart && cpuStall);
  endsequence
  a_unlock_reads_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    sfrReq.rd && sfrReq.addr == `PFT_REG_UNLOCK |=> sfrRdata == `PFT_BYTE_ZERO)
    else $error("unlock port read not zero");
  a_start_launches: assert property (@(posedge core_clk) disable iff (!arst_n)
    sqUnlocked ##0 (startReq && sfrReq.wdata[`PFT_BIT_WEN]) |-> sqLaunch)
    else $error("legal start did not launch");
  a_start_needs_unlock: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(writeGo) |-> $past(unlockState) == pft_pkg::PFT_UNL_OPEN && writeErr)
    else $error("write started without unlock");
  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!arst_n)
    eeRdStrobe |-> (!memSel && !cfgSel) ##1 !eeRdStrobe)
    else $error("read bit misbehaved");
  a_done_effects: assert property (@(posedge core_clk) disable iff (!arst_n)
    seqDone |=> !writeGo && nvWriteIrqFlag && !cpuStall && !writeErr)
    else $error("completion effects missing");
  a_stall_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    progStart |-> cpuStall throughout (##1 cpuStall [*2]))
    else $error("core not stalled during cycle");
  a_ptr_top_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
    tblAccept |=> table_pointer[`PFT_PTR_TOP] == $past(table_pointer[`PFT_PTR_TOP]))
    else $error("auto update moved pointer top bit");
  a_erase_block: assert property (@(posedge core_clk) disable iff (!arst_n)
    progStart && progCmd.erase |-> (progCmd.blockAddr & ~`PFT_ERASE_MASK) == '0)
    else $error("erase block not aligned");
  a_select_kept: assert property (@(posedge core_clk) disable iff (!powerOnRst_n)
    $rose(writeErr) && !ctrlWr |=> $stable(memSel) && $stable(cfgSel))
    else $error("select bits moved on error");
endmodule // pft_table_ctrl

// >>> testbench/pft_flash_model.sv
// Behavioural flash array read port that answers the table control block
`timescale 1ns/1ps
module pft_flash_model (
  input wire logic core_clk,
  input wire logic flashRdReq,
  input wire logic [21:0] flashRdAddr,
  output logic [7:0] flashRdData
);
  logic tog; // Flips every cycle so stale data never looks valid
  initial tog = 1'b0;
  always @(posedge core_clk) begin
    tog <= ~tog;
  end
  // Answer within the request cycle, so data is ready at the next edge
  always_comb begin
    if (flashRdReq) begin
      flashRdData = flashRdAddr[7:0] ^ flashRdAddr[15:8] ^ {flashRdAddr[21:16], 2'h3};
    end else begin
      flashRdData = {8{tog}} ^ 8'h5A; // Released: changing pattern
    end
  end
endmodule // pft_flash_model

// >>> testbench/pft_table_ctrl_tb_top.sv
// Self-checking bench for the table pointer and flash control block
`timescale 1ns/1ps
`include "pft_defines.svh"
module pft_table_ctrl_tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic powerOnRst_n = 1'b0;
  pft_pkg::pft_sfr_req_s sfrReq = '0;
  logic [7:0] sfrRdata, flashRdData, holdRdData;
  logic tblReq = 1'b0, tblWrite = 1'b0, irqFlagClr = 1'b0;
  pft_pkg::pft_ptr_mode_e tblMode = pft_pkg::PFT_PTR_KEEP;
  logic tblDone, flashRdReq, progStart, eeRdStrobe, cpuStall, nvWriteIrqFlag;
  logic [21:0] flashRdAddr;
  pft_pkg::pft_prog_cmd_s progCmd;
  logic [2:0] holdRdIdx = 3'h0;
  int errorCnt = 0, nChecks = 0;
  logic sawStart, sawEeRd, sawRdReq, sawDone;
  logic [21:0] sawAddr, ptr, got;
  logic [7:0] rd, hold [8];
  always #12.5 core_clk = ~core_clk;
  pft_table_ctrl #(.PROG_CYCLES(10), .HOLD_DEPTH(8)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .powerOnRst_n(powerOnRst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .tblReq(tblReq), .tblWrite(tblWrite), .tblMode(tblMode), .tblDone(tblDone),
    .flashRdReq(flashRdReq), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
    .progStart(progStart), .progCmd(progCmd), .holdRdIdx(holdRdIdx),
    .holdRdData(holdRdData), .eeRdStrobe(eeRdStrobe), .cpuStall(cpuStall),
    .irqFlagClr(irqFlagClr), .nvWriteIrqFlag(nvWriteIrqFlag));
  pft_flash_model farEnd (.core_clk(core_clk), .flashRdReq(flashRdReq),
    .flashRdAddr(flashRdAddr), .flashRdData(flashRdData));
  // Array contents as the bench expects them
  function automatic logic [7:0] fbyte(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {a[21:16], 2'h3};
  endfunction
  // Pointer steps touch the low 21 bits only
  function automatic logic [21:0] step(input logic [21:0] p, input logic up);
    return {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Drive just after the edge, the same delay every time
  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask
  // Register write; idle cycle after so strobes never change twice at once
  task automatic sfr_wr(input logic [2:0] a, input logic [7:0] d);
    sfrReq = {1'b0, 1'b1, a, d};
    tick;
    sawStart = progStart;
    sawEeRd = eeRdStrobe;
    sfrReq = '0;
    tick;
  endtask
  task automatic sfr_rd(input logic [2:0] a, output logic [7:0] d);
    sfrReq = {1'b1, 1'b0, a, 8'h00};
    tick;
    d = sfrRdata;
    sfrReq = '0;
    tick;
  endtask
  task automatic set_ptr(input logic [21:0] p);
    sfr_wr(`PFT_REG_PTRL, p[7:0]);
    sfr_wr(`PFT_REG_PTRH, p[15:8]);
    sfr_wr(`PFT_REG_PTRU, {2'h0, p[21:16]});
  endtask
  task automatic get_ptr(output logic [21:0] p);
    logic [7:0] l, h, u;
    sfr_rd(`PFT_REG_PTRL, l);
    sfr_rd(`PFT_REG_PTRH, h);
    sfr_rd(`PFT_REG_PTRU, u);
    check("upper pointer pad", u[7:6], 2'h0);
    p = {u[5:0], h, l};
  endtask
  // Table instruction; done comes one cycle later for writes, two for reads
  task automatic tbl_op(input logic w, input pft_pkg::pft_ptr_mode_e m);
    logic d1;
    tblReq = 1'b1;
    tblWrite = w;
    tblMode = m;
    tick;
    sawRdReq = flashRdReq;
    sawAddr = flashRdAddr;
    d1 = tblDone;
    tblReq = 1'b0;
    tick;
    sawDone = w ? d1 : tblDone;
  endtask
  task automatic unlock;
    sfr_wr(`PFT_REG_UNLOCK, `PFT_KEY_FIRST);
    sfr_wr(`PFT_REG_UNLOCK, `PFT_KEY_SECOND);
  endtask
  task automatic check_hold;
    for (int i = 0; i < 8; i++) begin
      holdRdIdx = i[2:0];
      tick;
      check("holding byte", holdRdData, hold[i]);
    end
  endtask
  // One legal self-timed cycle with the given select bits
  task automatic do_prog(input logic [7:0] sel, input pft_pkg::pft_target_e tgt,
                         input logic er);
    int n;
    ptr = 22'($urandom());
    set_ptr(ptr);
    sfr_wr(`PFT_REG_CTRL, sel | 8'h04);
    unlock;
    sfr_wr(`PFT_REG_CTRL, sel | 8'h06);
    check("start pulse", sawStart, 1'b1);
    check("target", progCmd.target, tgt);
    check("erase", progCmd.erase, er);
    check("block", progCmd.blockAddr, er ? {ptr[21:6], 6'h0} : {ptr[21:3], 3'h0});
    check("stall", cpuStall, 1'b1);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("busy control", rd & 8'h0A, 8'h0A);
    tbl_op(1'b0, pft_pkg::PFT_PTR_KEEP);
    check("read during stall", sawRdReq, 1'b0);
    n = 0;
    while (cpuStall === 1'b1 && n < 40) begin
      tick;
      n++;
    end
    check("stall ended", cpuStall, 1'b0);
    check("irq flag", nvWriteIrqFlag, 1'b1);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("done control", rd, (sel & 8'hC0) | 8'h04);
    irqFlagClr = 1'b1;
    tick;
    irqFlagClr = 1'b0;
    tick;
    check("irq cleared", nvWriteIrqFlag, 1'b0);
  endtask
  initial begin
    #(25 * 5000);
    errorCnt++;
    end_of_test;
  end
  initial begin
    logic [7:0] sels [4] = '{8'h80, 8'h90, 8'hC0, 8'h00};
    pft_pkg::pft_target_e tgts [4] = '{pft_pkg::PFT_TGT_FLASH, pft_pkg::PFT_TGT_FLASH,
                                       pft_pkg::PFT_TGT_CONFIG, pft_pkg::PFT_TGT_EEPROM};
    logic [21:0] base [4] = '{22'h0A5A5A, 22'h3FFFFF, 22'h200000, 22'h1FFFFF};
    logic [21:0] acc;
    pft_pkg::pft_ptr_mode_e m;
    void'($urandom(65493));
    repeat (12) @(posedge core_clk);
    #2;
    arst_n = 1'b1;
    powerOnRst_n = 1'b1;
    // Reset state, unlock port, unused bit, unmapped place
    sfr_rd(`PFT_REG_CTRL, rd);
    check("control at reset", rd, 8'h00);
    sfr_wr(`PFT_REG_UNLOCK, 8'h3C);
    sfr_rd(`PFT_REG_UNLOCK, rd);
    check("unlock reads", rd, 8'h00);
    sfr_wr(`PFT_REG_CTRL, 8'h20);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("unused bit", rd, 8'h00);
    sfr_rd(3'h6, rd);
    check("unmapped", rd, 8'h00);
    acc = 22'($urandom());
    set_ptr(acc);
    get_ptr(got);
    check("pointer", got, acc);
    $display("test registers done");
    // Table reads in every pointer mode, the three stepping modes at wrap boundaries
    for (int i = 0; i < 4; i++) begin
      m = pft_pkg::pft_ptr_mode_e'(i);
      set_ptr(base[i]);
      tbl_op(1'b0, m);
      acc = (m == pft_pkg::PFT_PTR_PREINC) ? step(base[i], 1'b1) : base[i];
      check("read request", sawRdReq, 1'b1);
      check("read address", sawAddr, acc);
      check("read done", sawDone, 1'b1);
      sfr_rd(`PFT_REG_LATCH, rd);
      check("latch", rd, fbyte(acc));
      get_ptr(got);
      check("pointer step", got, (m == pft_pkg::PFT_PTR_KEEP) ? base[i] :
            step(base[i], m != pft_pkg::PFT_PTR_POSTDEC));
    end
    $display("test table read done");
    // Four table writes from index 5, wrapping to 0
    for (int i = 0; i < 8; i++) hold[i] = `PFT_HOLD_RESET;
    ptr = {19'($urandom()), 3'h5};
    set_ptr(ptr);
    for (int i = 0; i < 4; i++) begin
      rd = 8'($urandom());
      hold[(5 + i) % 8] = rd;
      sfr_wr(`PFT_REG_LATCH, rd);
      tbl_op(1'b1, pft_pkg::PFT_PTR_POSTINC);
      check("write done", sawDone, 1'b1);
    end
    check_hold;
    get_ptr(got);
    check("pointer after writes", got, {ptr[21], ptr[20:0] + 21'h4});
    $display("test table write done");
    // Self-timed cycles on every target, with and without erase
    for (int i = 0; i < 4; i++) begin
      do_prog(sels[i], tgts[i], i == 1);
      if (i == 0) begin
        for (int k = 0; k < 8; k++) hold[k] = `PFT_HOLD_RESET;
        check_hold;
      end
    end
    $display("test self-timed cycles done");
    // Improper starts: no keys, enable clear, a write between the keys and the start
    sfr_wr(`PFT_REG_CTRL, 8'h86);
    check("no keys", sawStart, 1'b0);
    unlock;
    sfr_wr(`PFT_REG_CTRL, 8'h82);
    check("enable clear", sawStart, 1'b0);
    unlock;
    sfr_wr(`PFT_REG_LATCH, 8'h11);
    sfr_wr(`PFT_REG_CTRL, 8'h86);
    check("keys broken", sawStart, 1'b0);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("error kept", rd & 8'hCA, 8'h88);
    // Reset in mid-cycle leaves the error flag and the selects
    unlock;
    sfr_wr(`PFT_REG_CTRL, 8'h86);
    check("start", sawStart, 1'b1);
    arst_n = 1'b0;
    tick;
    arst_n = 1'b1;
    tick;
    check("stall after reset", cpuStall, 1'b0);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("error after reset", rd & 8'hC8, 8'h88);
    $display("test improper start done");
    // Data read bit: strobes for data memory, blocked for flash
    sfr_wr(`PFT_REG_CTRL, 8'h01);
    check("data read strobe", sawEeRd, 1'b1);
    sfr_rd(`PFT_REG_CTRL, rd);
    check("read bit cleared", rd[0], 1'b0);
    sfr_wr(`PFT_REG_CTRL, 8'h81);
    check("read blocked", sawEeRd, 1'b0);
    $display("test data read done");
    end_of_test;
  end
endmodule // pft_table_ctrl_tb_top
